//--- core/tcc_params.svh
// Register offsets, field positions and fixed values of the timer compare unit.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

`define TCC_ADDR_W 8
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_COUNT 8'h04
`define TCC_OFF_COMPARE 8'h08
`define TCC_OFF_FLAGS 8'h0C
`define TCC_OFF_STATUS 8'h10

`define TCC_CS_MSB 2
`define TCC_CS_LSB 0
`define TCC_WGM_MSB 4
`define TCC_WGM_LSB 3
`define TCC_COM_MSB 6
`define TCC_COM_LSB 5
`define TCC_FORCE_BIT 7
`define TCC_ASYNC_BIT 8
`define TCC_CMP_IE_BIT 9
`define TCC_OVF_IE_BIT 10
`define TCC_CTRL_W 11
`define TCC_CTRL_MASK 11'h77F
`define TCC_CTRL_RST 11'h000

`define TCC_CMF_BIT 0
`define TCC_OVF_BIT 1
`define TCC_STAT_OC_BIT 8

`define TCC_CS_STOP 3'h0
`define TCC_CS_DIRECT 3'h1
`define TCC_COM_OFF 2'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3

`define TCC_CNT_MAX 8'hFF
`define TCC_CNT_BOT 8'h00
`define TCC_CNT_ONE 8'h01
`define TCC_BYTE_RST 8'h00
`define TCC_WORD_ZERO 32'h0000_0000
`define TCC_HSIZE_WORD 3'h2

`endif

//--- core/tcc_pkg.sv
// Types shared by the timer compare unit.
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_WG_NORMAL = 2'b00,
    TCC_WG_PC_PWM = 2'b01,
    TCC_WG_CTC = 2'b10,
    TCC_WG_FAST_PWM = 2'b11
  } tcc_wave_mode_t;

  typedef enum logic {
    TCC_DIR_UP = 1'b0,
    TCC_DIR_DOWN = 1'b1
  } tcc_dir_t;
endpackage

//--- core/tcc_timer.sv
// Eight-bit counter and output compare unit with an AHB-Lite register slave.
// Summary of operation
// - Comparator flags equality of count and active compare
// - Bottom indicated when count is zero
// - Top/max indicated when count is all ones
// - Mode picks max or compare value as top
// - Tick from io clock, or oscillator when async
// - Each tick clears, increments or decrements count
// - Tick source field zero stops the counter
// - CPU reads and writes count any time
// - CPU count write beats hardware count or clear
// - Waveform mode sets sequence and overflow flag
// - Match sets compare flag on following tick
// - Enabled flag requests interrupt, cleared when serviced
// - Writing one clears compare flag, zero keeps
// - Output derived from match, max, bottom, modes
// - PWM modes double buffer compare, load at top
// - CPU reaches buffer when buffering, else active
// - Force strobe acts like match in non-PWM modes, no flag
// - Count write blocks match on next tick
// - Output register holds value across mode changes
// - Output mode bits take effect immediately
// - Output mode sets next state and pin source
// - Modes: 0 normal,1 phase PWM,2 CTC,3 fast
// - Normal mode wraps, overflow as count hits zero
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"

module tcc_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic osc_pin_one,
  input wire logic prescaled_tick,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic compare_output,
  output logic compare_port_select,
  output logic compare_irq,
  output logic overflow_irq
);

  logic [`TCC_CTRL_W-1:0] ctrl_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] compare_value_q;
  logic [7:0] compare_buf_q;
  logic compare_match_flag_q;
  logic overflow_flag_q;
  logic compare_output_q;
  logic compare_output_d;
  logic block_q;
  tcc_pkg::tcc_dir_t dir_q;
  logic [`TCC_ADDR_W-1:0] addr_q;
  logic wr_pend_q;
  logic [31:0] hrdata_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;

  default clocking tcc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Bus slave: every transfer completes with no wait state and an OKAY response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  logic take;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  assign take = hsel && htrans[1] && hready;
  assign wr_ctrl = wr_pend_q && (addr_q == `TCC_OFF_CTRL);
  assign wr_count = wr_pend_q && (addr_q == `TCC_OFF_COUNT);
  assign wr_compare = wr_pend_q && (addr_q == `TCC_OFF_COMPARE);
  assign wr_flags = wr_pend_q && (addr_q == `TCC_OFF_FLAGS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= `TCC_OFF_CTRL;
    end else begin
      // Only whole-word writes are accepted; other sizes are ignored.
      wr_pend_q <= take && hwrite && (hsize == `TCC_HSIZE_WORD);
      if (take) begin
        addr_q <= haddr[`TCC_ADDR_W-1:0];
      end
    end
  end

  // Mode decode.
  tcc_pkg::tcc_wave_mode_t mode;
  logic [1:0] com;
  logic [2:0] cs;
  logic pwm_mode;
  assign mode = tcc_pkg::tcc_wave_mode_t'(ctrl_q[`TCC_WGM_MSB:`TCC_WGM_LSB]);
  assign com = ctrl_q[`TCC_COM_MSB:`TCC_COM_LSB];
  assign cs = ctrl_q[`TCC_CS_MSB:`TCC_CS_LSB];
  assign pwm_mode = (mode == tcc_pkg::TCC_WG_PC_PWM) || (mode == tcc_pkg::TCC_WG_FAST_PWM);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `TCC_CTRL_RST;
    end else if (wr_ctrl) begin
      // The strobe bit is not stored; it always reads as zero.
      ctrl_q <= hwdata[`TCC_CTRL_W-1:0] & `TCC_CTRL_MASK;
    end
  end

  // The oscillator pin is foreign to hclk: two flops, then an edge detector on the second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_pin_one;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  logic tick;
  logic osc_rise;
  assign osc_rise = osc_s2_q && !osc_s3_q;
  always_comb begin
    if (cs == `TCC_CS_STOP) begin
      tick = 1'b0;
    end else if (ctrl_q[`TCC_ASYNC_BIT]) begin
      tick = osc_rise;
    end else if (cs == `TCC_CS_DIRECT) begin
      tick = 1'b1;
    end else begin
      tick = prescaled_tick;
    end
  end

  // Comparator and extreme-value detectors.
  logic match;
  logic at_max;
  logic at_bot;
  logic hit;
  assign match = (count_q == compare_value_q);
  assign at_max = (count_q == `TCC_CNT_MAX);
  assign at_bot = (count_q == `TCC_CNT_BOT);
  assign hit = tick && match && !block_q;

  // Next count for one tick of the selected sequence.
  always_comb begin
    case (mode)
      tcc_pkg::TCC_WG_NORMAL: count_d = count_q + `TCC_CNT_ONE;
      tcc_pkg::TCC_WG_CTC: count_d = (match && !block_q) ? `TCC_CNT_BOT
                                                         : count_q + `TCC_CNT_ONE;
      tcc_pkg::TCC_WG_FAST_PWM: count_d = count_q + `TCC_CNT_ONE;
      tcc_pkg::TCC_WG_PC_PWM: begin
        if (dir_q == tcc_pkg::TCC_DIR_DOWN) begin
          count_d = at_bot ? count_q + `TCC_CNT_ONE : count_q - `TCC_CNT_ONE;
        end else begin
          count_d = at_max ? count_q - `TCC_CNT_ONE : count_q + `TCC_CNT_ONE;
        end
      end
      default: count_d = count_q;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `TCC_BYTE_RST;
    end else if (wr_count) begin
      count_q <= hwdata[7:0];
    end else if (tick) begin
      count_q <= count_d;
    end
  end

  // The block lasts until the next tick, however long the timer is stopped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= tcc_pkg::TCC_DIR_UP;
    end else if (mode != tcc_pkg::TCC_WG_PC_PWM) begin
      dir_q <= tcc_pkg::TCC_DIR_UP;
    end else if (tick && !wr_count) begin
      if (at_max) begin
        dir_q <= tcc_pkg::TCC_DIR_DOWN;
      end else if (at_bot) begin
        dir_q <= tcc_pkg::TCC_DIR_UP;
      end
    end
  end

  // Compare value: buffered in PWM modes and loaded when the count sits at max.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value_q <= `TCC_BYTE_RST;
      compare_buf_q <= `TCC_BYTE_RST;
    end else begin
      if (wr_compare) begin
        compare_buf_q <= hwdata[7:0];
      end
      if (wr_compare && !pwm_mode) begin
        compare_value_q <= hwdata[7:0];
      end else if (pwm_mode && tick && at_max) begin
        compare_value_q <= compare_buf_q;
      end
    end
  end

  // Overflow event per mode.
  logic ovf_ev;
  always_comb begin
    case (mode)
      tcc_pkg::TCC_WG_PC_PWM: ovf_ev = tick && at_bot && (dir_q == tcc_pkg::TCC_DIR_DOWN);
      default: ovf_ev = tick && at_max;
    endcase
  end

  // Flags: a hardware set in the same cycle as a clear wins.
  logic cmf_clr;
  logic ovf_clr;
  assign cmf_clr = (wr_flags && hwdata[`TCC_CMF_BIT]) || compare_irq_ack;
  assign ovf_clr = (wr_flags && hwdata[`TCC_OVF_BIT]) || overflow_irq_ack;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_match_flag_q <= 1'b0;
    end else if (hit) begin
      compare_match_flag_q <= 1'b1;
    end else if (cmf_clr) begin
      compare_match_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf_ev) begin
      overflow_flag_q <= 1'b1;
    end else if (ovf_clr) begin
      overflow_flag_q <= 1'b0;
    end
  end

  assign compare_irq = compare_match_flag_q && ctrl_q[`TCC_CMP_IE_BIT];
  assign overflow_irq = overflow_flag_q && ctrl_q[`TCC_OVF_IE_BIT];

  // Waveform generator. At max equal to compare, the bottom action is applied last,
  // so the fast PWM output stays constant instead of glitching.
  logic force_ev;
  logic [1:0] force_com;
  assign force_com = hwdata[`TCC_COM_MSB:`TCC_COM_LSB];
  assign force_ev = wr_ctrl && hwdata[`TCC_FORCE_BIT] && !hwdata[`TCC_WGM_LSB];

  always_comb begin
    compare_output_d = compare_output_q;
    case (mode)
      tcc_pkg::TCC_WG_FAST_PWM: begin
        if (hit) begin
          if (com == `TCC_COM_TOGGLE) begin
            compare_output_d = !compare_output_q;
          end else if (com == `TCC_COM_CLEAR) begin
            compare_output_d = 1'b0;
          end else if (com == `TCC_COM_SET) begin
            compare_output_d = 1'b1;
          end
        end
        if (tick && at_max) begin
          if (com == `TCC_COM_CLEAR) begin
            compare_output_d = 1'b1;
          end else if (com == `TCC_COM_SET) begin
            compare_output_d = 1'b0;
          end
        end
      end
      tcc_pkg::TCC_WG_PC_PWM: begin
        if (hit && (com == `TCC_COM_CLEAR)) begin
          compare_output_d = (dir_q == tcc_pkg::TCC_DIR_DOWN);
        end else if (hit && (com == `TCC_COM_SET)) begin
          compare_output_d = (dir_q == tcc_pkg::TCC_DIR_UP);
        end
      end
      default: begin
        if (hit) begin
          if (com == `TCC_COM_TOGGLE) begin
            compare_output_d = !compare_output_q;
          end else if (com == `TCC_COM_CLEAR) begin
            compare_output_d = 1'b0;
          end else if (com == `TCC_COM_SET) begin
            compare_output_d = 1'b1;
          end
        end
      end
    endcase
    if (force_ev && (force_com != `TCC_COM_OFF)) begin
      compare_output_d = (force_com == `TCC_COM_TOGGLE) ? !compare_output_q : force_com[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_output_q <= 1'b0;
    end else begin
      compare_output_q <= compare_output_d;
    end
  end

  assign compare_output = compare_output_q;
  // Toggle has no meaning in phase correct PWM, so the pin stays with the port there.
  assign compare_port_select = (com != `TCC_COM_OFF) &&
                               !((mode == tcc_pkg::TCC_WG_PC_PWM) &&
                                 (com == `TCC_COM_TOGGLE));

  // Read data is sampled in the address phase and stands through the data phase.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `TCC_WORD_ZERO;
    case (haddr[`TCC_ADDR_W-1:0])
      `TCC_OFF_CTRL: rd_mux[`TCC_CTRL_W-1:0] = ctrl_q;
      `TCC_OFF_COUNT: rd_mux[7:0] = count_q;
      `TCC_OFF_COMPARE: rd_mux[7:0] = pwm_mode ? compare_buf_q : compare_value_q;
      `TCC_OFF_FLAGS: begin
        rd_mux[`TCC_CMF_BIT] = compare_match_flag_q;
        rd_mux[`TCC_OVF_BIT] = overflow_flag_q;
      end
      `TCC_OFF_STATUS: begin
        rd_mux[7:0] = compare_value_q;
        rd_mux[`TCC_STAT_OC_BIT] = compare_output_q;
      end
      default: rd_mux = `TCC_WORD_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `TCC_WORD_ZERO;
    end else if (take && !hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  sequence s_write_then_tick;
    wr_count ##1 tick;
  endsequence

  sequence s_pwm_hold;
    pwm_mode && !(tick && at_max) && !wr_ctrl;
  endsequence

  AST_FLAG_AFTER_MATCH: assert property (tick && match && !block_q |=> compare_match_flag_q)
    else $error("compare flag not set after match tick");
  AST_WRITE_BLOCKS: assert property (s_write_then_tick |-> !hit)
    else $error("match not blocked after count write");
  AST_WRITE_WINS: assert property (wr_count |=> count_q == $past(hwdata[7:0]))
    else $error("count write lost to hardware update");
  AST_STOPPED: assert property (cs == `TCC_CS_STOP && !wr_count |=> $stable(count_q))
    else $error("count moved while stopped");
  AST_NORMAL_WRAP: assert property (mode == tcc_pkg::TCC_WG_NORMAL && tick && at_max && !wr_count
    |=> count_q == `TCC_CNT_BOT && overflow_flag_q)
    else $error("normal mode wrap without overflow");
  AST_BUFFER_HOLD: assert property (s_pwm_hold |=> $stable(compare_value_q))
    else $error("active compare changed away from max");
  AST_FORCE_NO_FLAG: assert property (force_ev && !tick && !compare_match_flag_q
    |=> !compare_match_flag_q)
    else $error("force strobe set compare flag");
  AST_FLAG_CLEAR: assert property (wr_flags && hwdata[`TCC_CMF_BIT] && !hit
    |=> !compare_match_flag_q)
    else $error("write one did not clear compare flag");
  AST_CTC_CLEAR: assert property (mode == tcc_pkg::TCC_WG_CTC && hit && !wr_count
    |=> count_q == `TCC_CNT_BOT)
    else $error("CTC did not clear on match");

endmodule

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the timer compare unit, driven through the host bus model.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"

module tb;
  localparam logic [7:0] o_ctl = `TCC_OFF_CTRL;
  localparam logic [7:0] o_cnt = `TCC_OFF_COUNT;
  localparam logic [7:0] o_cmp = `TCC_OFF_COMPARE;
  localparam logic [7:0] o_flg = `TCC_OFF_FLAGS;
  localparam logic [7:0] o_sts = `TCC_OFF_STATUS;
  localparam tcc_pkg::tcc_wave_mode_t nrm = tcc_pkg::TCC_WG_NORMAL;
  localparam tcc_pkg::tcc_wave_mode_t ctc = tcc_pkg::TCC_WG_CTC;
  localparam tcc_pkg::tcc_wave_mode_t fst = tcc_pkg::TCC_WG_FAST_PWM;
  localparam tcc_pkg::tcc_wave_mode_t pcp = tcc_pkg::TCC_WG_PC_PWM;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic osc_pin_one = 1'b0;
  logic prescaled_tick = 1'b0;
  logic compare_irq_ack = 1'b0;
  logic overflow_irq_ack = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, compare_output, compare_port_select;
  logic compare_irq, overflow_irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2.5 hclk = ~hclk;

  tcc_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  tcc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_pin_one(osc_pin_one),
    .prescaled_tick(prescaled_tick), .compare_irq_ack(compare_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .compare_output(compare_output),
    .compare_port_select(compare_port_select), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq));

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    host.xfer(1'b1, off, d, rdv);
  endtask

  task automatic rchk(input logic [7:0] off, input logic [31:0] exp);
    host.xfer(1'b0, off, 32'h0000_0000, rdv);
    chk(rdv, exp);
  endtask

  // The extra idle cycle lets a registered tick land before the next read is taken.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge hclk);
      prescaled_tick <= 1'b1;
      @(posedge hclk);
      prescaled_tick <= 1'b0;
    end
    @(posedge hclk);
  endtask

  task automatic ack(input logic cmp);
    @(posedge hclk);
    compare_irq_ack <= cmp;
    overflow_irq_ack <= ~cmp;
    @(posedge hclk);
    compare_irq_ack <= 1'b0;
    overflow_irq_ack <= 1'b0;
  endtask

  // The ext field packs overflow enable, compare enable, async select and force strobe.
  function automatic logic [31:0] cw(input logic [2:0] cs, input tcc_pkg::tcc_wave_mode_t wg,
      input logic [1:0] com, input logic [3:0] ext);
    return {21'h00_0000, ext, com, wg, cs};
  endfunction

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rchk(8'(i * 4), 32'h0000_0000);
    end
    pin(compare_output, 1'b0);
    pin(hresp, 1'b0);
    pin(hreadyout, 1'b1);
    wr(8'h20, 32'hFFFF_FFFF);
    rchk(8'h20, 32'h0000_0000);
    // Phase correct goes first while the direction is still up from reset.
    wr(o_cnt, 32'h0000_00FE);
    wr(o_ctl, cw(3'h2, pcp, `TCC_COM_OFF, 4'h0));
    tick(1);
    rchk(o_cnt, 32'h0000_00FF);
    tick(1);
    rchk(o_cnt, 32'h0000_00FE);
    wr(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_OFF, 4'h0));
    wr(o_cnt, 32'h0000_0005);
    tick(2);
    rchk(o_cnt, 32'h0000_0005);
    wr(o_cmp, 32'h0000_00FE);
    rchk(o_sts, 32'h0000_00FE);
    wr(o_cnt, 32'h0000_00FD);
    wr(o_ctl, cw(3'h2, nrm, `TCC_COM_OFF, 4'hC));
    tick(1);
    rchk(o_flg, 32'h0000_0000);
    tick(1);
    rchk(o_flg, 32'h0000_0001);
    pin(compare_irq, 1'b1);
    tick(1);
    rchk(o_cnt, 32'h0000_0000);
    rchk(o_flg, 32'h0000_0003);
    pin(overflow_irq, 1'b1);
    wr(o_flg, 32'h0000_0000);
    rchk(o_flg, 32'h0000_0003);
    ack(1'b1);
    rchk(o_flg, 32'h0000_0002);
    pin(compare_irq, 1'b0);
    ack(1'b0);
    rchk(o_flg, 32'h0000_0000);
    wr(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_OFF, 4'h0));
    wr(o_cmp, 32'h0000_0010);
    wr(o_cnt, 32'h0000_0010);
    wr(o_ctl, cw(3'h2, nrm, `TCC_COM_OFF, 4'h0));
    tick(1);
    rchk(o_flg, 32'h0000_0000);
    rchk(o_cnt, 32'h0000_0011);
    wr(o_cmp, 32'h0000_0003);
    wr(o_cnt, 32'h0000_0000);
    wr(o_ctl, cw(3'h2, ctc, `TCC_COM_TOGGLE, 4'h0));
    @(negedge hclk);
    pin(compare_port_select, 1'b1);
    tick(4);
    rchk(o_cnt, 32'h0000_0000);
    rchk(o_sts, 32'h0000_0103);
    rchk(o_flg, 32'h0000_0001);
    wr(o_flg, 32'h0000_0001);
    rchk(o_flg, 32'h0000_0000);
    wr(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_CLEAR, 4'h1));
    rchk(o_sts, 32'h0000_0003);
    rchk(o_flg, 32'h0000_0000);
    rchk(o_cnt, 32'h0000_0000);
    wr(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_SET, 4'h1));
    rchk(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_SET, 4'h0));
    pin(compare_output, 1'b1);
    wr(o_ctl, cw(`TCC_CS_STOP, fst, `TCC_COM_OFF, 4'h0));
    @(negedge hclk);
    pin(compare_output, 1'b1);
    pin(compare_port_select, 1'b0);
    wr(o_cmp, 32'h0000_0020);
    rchk(o_sts, 32'h0000_0103);
    rchk(o_cmp, 32'h0000_0020);
    wr(o_cnt, 32'h0000_00FE);
    wr(o_ctl, cw(3'h2, fst, `TCC_COM_OFF, 4'h0));
    tick(2);
    host.xfer(1'b0, o_sts, 32'h0000_0000, rdv);
    chk({24'h00_0000, rdv[7:0]}, 32'h0000_0020);
    rchk(o_cnt, 32'h0000_0000);
    rchk(o_flg, 32'h0000_0002);
    wr(o_ctl, cw(`TCC_CS_DIRECT, nrm, `TCC_COM_OFF, 4'h2));
    repeat (3) begin
      repeat (4) @(posedge hclk);
      osc_pin_one <= 1'b1;
      repeat (4) @(posedge hclk);
      osc_pin_one <= 1'b0;
    end
    repeat (4) @(posedge hclk);
    wr(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_OFF, 4'h0));
    rchk(o_cnt, 32'h0000_0003);
    // With a tick on every clock, the count write lands just before a matching tick.
    wr(o_flg, 32'h0000_0003);
    wr(o_ctl, cw(`TCC_CS_DIRECT, nrm, `TCC_COM_OFF, 4'h0));
    wr(o_cnt, 32'h0000_0020);
    wr(o_ctl, cw(`TCC_CS_STOP, nrm, `TCC_COM_OFF, 4'h0));
    rchk(o_flg, 32'h0000_0000);
    rchk(o_cnt, 32'h0000_0023);
    results();
  end
endmodule

`default_nettype wire

//--- tb/tcc_host.sv
// Bus master model that stands in for the host processor on the register bus.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"

module tcc_host (
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `TCC_HSIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // Released lines carry inverted values, so stale data can never pass for a fresh answer.
  // Callers keep count and compare apart unless a blocked match is wanted.
  task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                      output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, off};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= `TCC_HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{24'h00_0000, off};
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

`default_nettype wire
